// ==== rtl/glitch_filter.sv ====
// Two-flop synchroniser followed by an optional pulse-width filter.
// Assumes raw is asynchronous to clk and idles high.
module glitch_filter
    import serial_port_pkg::*;
#(
    parameter int STABLE_CYCLES = FILTER_CYCLES
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic enable,
    input  wire logic raw,
    output logic      filtered_q
);

    localparam int CNT_W = $clog2(STABLE_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STABLE_CYCLES - 1);

    logic             sync1_q;
    logic             sync2_q;
    logic [CNT_W-1:0] count_q;

    // --------------------------------------------------------------
    // Synchroniser
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_q <= LINE_IDLE;
            sync2_q <= LINE_IDLE;
        end else begin
            sync1_q <= raw;
            sync2_q <= sync1_q;
        end
    end

    // --------------------------------------------------------------
    // Level passes only after holding for the full window
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            filtered_q <= LINE_IDLE;
            count_q    <= '0;
        end else if (!enable) begin
            filtered_q <= sync2_q;                  // Bypass
            count_q    <= '0;
        end else if (sync2_q == filtered_q) begin
            count_q    <= '0;                       // Short pulse dropped
        end else if (count_q == CNT_LAST) begin
            filtered_q <= sync2_q;
            count_q    <= '0;
        end else begin
            count_q    <= count_q + 1'b1;
        end
    end

endmodule : glitch_filter

// ==== rtl/reg_bank.sv ====
// Control register storage with a registered read port.
// Assumes one writer; reset loads the default image.
module reg_bank
    import serial_port_pkg::*;
#(
    parameter int                       NUM_REGS   = 16,
    parameter int                       ADDR_W     = $clog2(NUM_REGS),
    parameter logic [NUM_REGS*8-1:0]    RESET_IMG  = '0
) (
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire logic                  wrEn,
    input  wire logic [ADDR_W-1:0]     wrAddr,
    input  wire logic [7:0]            wrData,
    input  wire logic [ADDR_W-1:0]     rdAddr,
    output logic      [7:0]            rdData_q,
    output logic      [NUM_REGS*8-1:0] regs_q
);

    // --------------------------------------------------------------
    // Storage, restored to defaults on reset
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            regs_q <= RESET_IMG;
        end else if (wrEn) begin
            regs_q[wrAddr*8 +: 8] <= wrData;
        end
    end

    // --------------------------------------------------------------
    // Registered read
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdData_q <= BYTE_RESET;
        end else begin
            rdData_q <= regs_q[rdAddr*8 +: 8];
        end
    end

endmodule : reg_bank

// ==== rtl/serial_port_pkg.sv ====
// Shared constants and types for the two-wire register port.
// Assumes a 200 MHz ref_clk; the filter cycle count below derives from that rate.
package serial_port_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;     // ref_clk period
    localparam int FILTER_NS     = 50;    // Shortest pulse that passes
    // Least time, so round up to whole cycles
    localparam int FILTER_CYCLES =
        (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Protocol fields
    // ------------------------------------------------------------------
    localparam logic [6:0] SLAVE_ADDR_BASE = 7'h2A; // Arbitrary value
    localparam int         ADDR_SEL_POS    = 0;     // Pin-set address bit
    localparam int         DIR_BIT_POS     = 0;     // Direction in byte 1
    localparam int         POINTER_MSB_POS = 7;     // Must be zero
    localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
    localparam logic [7:0] POINTER_RESET   = 8'h00;
    localparam logic [7:0] BYTE_RESET      = 8'h00;
    localparam logic       LINE_IDLE       = 1'b1;  // Released bus level

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic scl;
        logic sda;
    } lines_t;

    typedef enum logic [8:0] {
        ST_IDLE      = 9'h001,
        ST_ADDR      = 9'h002,
        ST_ADDR_ACK  = 9'h004,
        ST_SUB       = 9'h008,
        ST_SUB_ACK   = 9'h010,
        ST_WDATA     = 9'h020,
        ST_WDATA_ACK = 9'h040,
        ST_RDATA     = 9'h080,
        ST_RDATA_ACK = 9'h100
    } portState_t;

endpackage : serial_port_pkg

// ==== rtl/serial_register_port.sv ====
// Two-wire serial slave giving a host access to the control registers.
// Assumes scl and sdaIn come from pins; the open-drain wire is resolved
// outside from sdaOe (low driven while sdaOe is high).
module serial_register_port
    import serial_port_pkg::*;
#(
    parameter int                    NUM_REGS   = 16,
    parameter logic [NUM_REGS*8-1:0] REG_RESET  = '0,
    parameter int                    FILTER_CYC = FILTER_CYCLES
) (
    input  wire logic                  ref_clk,
    input  wire logic                  reset_n,
    input  wire logic                  scl,
    input  wire logic                  sdaIn,
    output logic                       sdaOut,
    output logic                       sdaOe,
    input  wire logic                  addrSelectPin,
    output logic      [NUM_REGS*8-1:0] ctrlRegs
);

    // Bank geometry
    localparam int         ADDR_W   = $clog2(NUM_REGS);
    localparam logic [7:0] LAST_REG = 8'(NUM_REGS - 1);
    localparam logic [7:0] REG_CNT  = 8'(NUM_REGS);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    // Filtered lines, their previous levels, state and synchronised select
    lines_t           now;
    lines_t           prev_q;
    portState_t       state_q;
    logic             sel1_q;
    logic             selectSync_q;
    // Byte framing, shifters and pointer
    logic [3:0]       bitCnt_q;
    logic [7:0]       rxShift_q;
    logic [7:0]       txShift_q;
    logic [7:0]       pointer_q;
    logic             readDir_q;
    logic             masterAck_q;
    // Write and read ports toward the bank
    logic             wrEn_q;
    logic [ADDR_W-1:0] wrAddr_q;
    logic [7:0]       wrData_q;
    logic [7:0]       rdData;
    logic [ADDR_W-1:0] rdAddr;
    // Bus events and decisions
    logic             sclRise;
    logic             sclFall;
    logic             startSeen;
    logic             stopSeen;
    logic             byteDone;
    logic             addrMatch;
    logic             subValid;

    // ------------------------------------------------------------------
    // Line conditioning
    // ------------------------------------------------------------------
    // Select pin synchronised before it steers anything
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sel1_q       <= 1'b0;
            selectSync_q <= 1'b0;
        end else begin
            sel1_q       <= addrSelectPin;
            selectSync_q <= sel1_q;
        end
    end

    // Clock and data filters, enabled by the select pin
    glitch_filter #(.STABLE_CYCLES(FILTER_CYC)) sclFilter (
        .clk        (ref_clk),
        .reset_n    (reset_n),
        .enable     (selectSync_q),
        .raw        (scl),
        .filtered_q (now.scl)
    );

    glitch_filter #(.STABLE_CYCLES(FILTER_CYC)) sdaFilter (
        .clk        (ref_clk),
        .reset_n    (reset_n),
        .enable     (selectSync_q),
        .raw        (sdaIn),
        .filtered_q (now.sda)
    );

    // Previous levels for edge detection
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_q <= '{scl: LINE_IDLE, sda: LINE_IDLE};
        end else begin
            prev_q <= now;
        end
    end

    // ------------------------------------------------------------------
    // Bus events and decisions
    // ------------------------------------------------------------------
    // Filtered clock edges
    assign sclRise   = now.scl & ~prev_q.scl;
    assign sclFall   = ~now.scl & prev_q.scl;
    // Data edges while clock stays high
    assign startSeen = now.scl & prev_q.scl & prev_q.sda & ~now.sda;
    assign stopSeen  = now.scl & prev_q.scl & ~prev_q.sda &
                       now.sda;
    // Full byte counted
    assign byteDone  = (bitCnt_q == BITS_PER_BYTE);
    // Address bit 0 follows the select pin
    assign addrMatch = (rxShift_q[7:1] ==
        {SLAVE_ADDR_BASE[6:1], selectSync_q});
    // Top bit zero and index inside the bank
    assign subValid  = ~rxShift_q[POINTER_MSB_POS] &
                       (rxShift_q < REG_CNT);
    // Clamp reads at the highest register
    assign rdAddr    = (pointer_q > LAST_REG) ? LAST_REG[ADDR_W-1:0]
                                              : pointer_q[ADDR_W-1:0];

    // ------------------------------------------------------------------
    // Protocol sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q     <= ST_IDLE;
            bitCnt_q    <= '0;
            rxShift_q   <= BYTE_RESET;
            txShift_q   <= BYTE_RESET;
            pointer_q   <= POINTER_RESET;
            readDir_q   <= 1'b0;
            masterAck_q <= 1'b0;
            sdaOe       <= 1'b0;
            wrEn_q      <= 1'b0;
            wrAddr_q    <= '0;
            wrData_q    <= BYTE_RESET;
        end else begin
            // Write strobe lasts one cycle
            wrEn_q <= 1'b0;
            if (startSeen) begin
                // Any start restarts address reception
                state_q  <= ST_ADDR;
                bitCnt_q <= '0;
                sdaOe    <= 1'b0;
            end else if (stopSeen) begin
                state_q  <= ST_IDLE;
                bitCnt_q <= '0;
                sdaOe    <= 1'b0;
            end else if (sclRise) begin
                case (state_q)
                    // Receive states sample data on every rise
                    ST_ADDR, ST_SUB, ST_WDATA: begin
                        if (!byteDone) begin
                            // MSB first shift
                            rxShift_q <= {rxShift_q[6:0], now.sda};
                            bitCnt_q  <= bitCnt_q + 4'h1;
                        end
                    end
                    // Master's answer to a read byte
                    ST_RDATA_ACK: begin
                        masterAck_q <= ~now.sda;
                        if (pointer_q < LAST_REG) begin
                            pointer_q <= pointer_q + 8'h01;
                        end
                    end
                    // Other states ignore rises
                    default: begin
                    end
                endcase
            end else if (sclFall) begin
                case (state_q)
                    // Address byte complete: ack on match
                    ST_ADDR: begin
                        if (byteDone && addrMatch) begin
                            readDir_q <= rxShift_q[DIR_BIT_POS];
                            sdaOe     <= 1'b1;
                            state_q   <= ST_ADDR_ACK;
                        end else if (byteDone) begin
                            state_q   <= ST_IDLE;
                        end
                    end
                    // End of address ack; turn round for reads
                    ST_ADDR_ACK: begin
                        sdaOe    <= 1'b0;
                        bitCnt_q <= '0;
                        if (readDir_q) begin
                            // Read begins at the stored pointer
                            txShift_q <= {rdData[6:0], 1'b0};
                            sdaOe     <= ~rdData[7];
                            bitCnt_q  <= 4'h1;
                            state_q   <= ST_RDATA;
                        end else begin
                            state_q   <= ST_SUB;
                        end
                    end
                    // Pointer byte complete
                    ST_SUB: begin
                        if (byteDone && subValid) begin
                            pointer_q <= rxShift_q;
                            sdaOe     <= 1'b1;
                            state_q   <= ST_SUB_ACK;
                        end else if (byteDone) begin
                            state_q   <= ST_IDLE;
                        end
                    end
                    // Data byte complete: write if in range
                    ST_WDATA: begin
                        if (byteDone && pointer_q < REG_CNT) begin
                            wrEn_q    <= 1'b1;
                            wrAddr_q  <= pointer_q[ADDR_W-1:0];
                            wrData_q  <= rxShift_q;
                            pointer_q <= pointer_q + 8'h01;
                            sdaOe     <= 1'b1;
                            state_q   <= ST_WDATA_ACK;
                        end else if (byteDone) begin
                            state_q   <= ST_IDLE;
                        end
                    end
                    // Release the ack, then take the next data byte
                    ST_SUB_ACK, ST_WDATA_ACK: begin
                        sdaOe    <= 1'b0;
                        bitCnt_q <= '0;
                        state_q  <= ST_WDATA;
                    end
                    // Drive the next read bit while the clock is low
                    ST_RDATA: begin
                        if (byteDone) begin
                            sdaOe   <= 1'b0;        // Master's ack slot
                            state_q <= ST_RDATA_ACK;
                        end else begin
                            sdaOe     <= ~txShift_q[7];
                            txShift_q <= {txShift_q[6:0], 1'b0};
                            bitCnt_q  <= bitCnt_q + 4'h1;
                        end
                    end
                    // Continue on master ack, else stop driving
                    ST_RDATA_ACK: begin
                        if (masterAck_q) begin
                            // Clamped pointer repeats the top register
                            txShift_q <= {rdData[6:0], 1'b0};
                            sdaOe     <= ~rdData[7];
                            bitCnt_q  <= 4'h1;
                            state_q   <= ST_RDATA;
                        end else begin
                            state_q   <= ST_IDLE;
                        end
                    end
                    // Unused codes recover to idle
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Data pin is only ever pulled low
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sdaOut <= 1'b0;
        end else begin
            sdaOut <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    // Bank written by the sequencer, read at the pointer
    reg_bank #(
        .NUM_REGS  (NUM_REGS),
        .ADDR_W    (ADDR_W),
        .RESET_IMG (REG_RESET)
    ) regs (
        .clk      (ref_clk),
        .reset_n  (reset_n),
        .wrEn     (wrEn_q),
        .wrAddr   (wrAddr_q),
        .wrData   (wrData_q),
        .rdAddr   (rdAddr),
        .rdData_q (rdData),
        .regs_q   (ctrlRegs)
    );

endmodule : serial_register_port

// ==== sim/host_master.sv ====
// Behavioural bus master driving the clock and pulling data low.
// Assumes a pull-up on the data wire; bit time is 13 ref_clk cycles.
module host_master (
    input  wire logic clk,
    input  wire logic sdaLine,
    output logic      scl,
    output logic      hostLow
);
    timeunit 1ns;
    timeprecision 1ps;

    // Bus idles released, clock high
    initial begin
        scl = 1'b1;
        hostLow = 1'b0;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    // Data falls while clock high; one per high phase
    task automatic start();
        hostLow = 1'b0;
        cyc(3);
        scl = 1'b1;
        cyc(3);
        hostLow = 1'b1;
        cyc(3);
        scl = 1'b0;
    endtask : start

    // Data rises while clock high; clock stays high after
    task automatic stop();
        cyc(3);
        hostLow = 1'b1;
        cyc(4);
        scl = 1'b1;
        cyc(3);
        hostLow = 1'b0;
        cyc(6);
    endtask : stop

    // One bit; optional one-cycle clock glitch in the low phase
    task automatic bitx(input logic v, input logic gl, output logic s);
        cyc(3);
        hostLow = !v;
        cyc(2);
        if (gl) scl = 1'b1;
        cyc(1);
        scl = 1'b0;
        cyc(1);
        scl = 1'b1;
        cyc(3);
        s = sdaLine;
        cyc(3);
        scl = 1'b0;
    endtask : bitx

    // MSB first; full bytes get the ninth clock
    task automatic sendByte(input logic [7:0] b, input int nb,
                            input logic gl, output logic ack);
        logic s;
        ack = 1'b0;
        for (int i = 0; i < nb; i++) bitx(b[7-i], gl && i == 3, s);
        if (nb == 8) begin
            bitx(1'b1, 1'b0, s);
            ack = !s;
        end
    endtask : sendByte

    // Master nack on the ninth clock ends a read
    task automatic readByte(input logic mAck, output logic [7:0] b);
        logic s;
        for (int i = 0; i < 8; i++) bitx(1'b1, 1'b0, b[7-i]);
        bitx(!mAck, 1'b0, s);
    endtask : readByte
endmodule : host_master

// ==== sim/serial_register_port_asserts.sv ====
// Checker for the two-wire register port, bound to its top module.
// Assumes the data pin is open drain with sdaIn the resolved wire.
module serial_register_port_asserts
    import serial_port_pkg::*;
#(
    parameter int                    NUM_REGS  = 16,
    parameter logic [NUM_REGS*8-1:0] REG_RESET = '0
) (
    input wire logic                  ref_clk,
    input wire logic                  reset_n,
    input wire logic                  scl,
    input wire logic                  sdaIn,
    input wire logic                  sdaOut,
    input wire logic                  sdaOe,
    input wire logic                  addrSelectPin,
    input wire logic [NUM_REGS*8-1:0] ctrlRegs
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [NUM_REGS*8-1:0] prevRegs_q;
    logic [NUM_REGS-1:0]   byteDiff;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // Last register image, to spot multi-byte updates
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) prevRegs_q <= REG_RESET;
        else          prevRegs_q <= ctrlRegs;
    end

    // Bytes that differ from the last image
    always_comb begin
        for (int i = 0; i < NUM_REGS; i++)
            byteDiff[i] = ctrlRegs[8*i+:8] != prevRegs_q[8*i+:8];
    end

    oe_drives_low_a: assert property (sdaOe |-> !sdaOut)
        else $error("data driven high while enabled");
    reset_defaults_a: assert property (
        disable iff (1'b0) !reset_n |-> ctrlRegs == REG_RESET)
        else $error("register image not at default in reset");
    one_byte_a: assert property ($countones(byteDiff) <= 1)
        else $error("several registers written at once");
    write_acked_a: assert property ($changed(ctrlRegs) |-> sdaOe)
        else $error("register written without acknowledge");
    ack_in_low_a: assert property ($changed(sdaOe) |-> !scl)
        else $error("data drive changed while clock high");
    oe_bounded_a: assert property (
        $rose(sdaOe) |-> ##[1:200] !sdaOe)
        else $error("data line held too long");
    stop_release_a: assert property (
        scl && $past(scl) && $rose(sdaIn) |-> !sdaOe [*8])
        else $error("data driven after stop");
    start_release_a: assert property (
        scl && $past(scl) && $fell(sdaIn) |-> !sdaOe [*8])
        else $error("data driven right after start");
endmodule : serial_register_port_asserts

bind serial_register_port serial_register_port_asserts #(
    .NUM_REGS (NUM_REGS),
    .REG_RESET(REG_RESET)
) u_serial_register_port_asserts (
    .ref_clk      (ref_clk),
    .reset_n      (reset_n),
    .scl          (scl),
    .sdaIn        (sdaIn),
    .sdaOut       (sdaOut),
    .sdaOe        (sdaOe),
    .addrSelectPin(addrSelectPin),
    .ctrlRegs     (ctrlRegs)
);

// ==== sim/serial_register_port_bench.sv ====
// Self-checking bench for the two-wire register port.
// Assumes host_master as far side and the bound checker.
module serial_register_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import serial_port_pkg::*;

    localparam int              NR  = 4;
    localparam logic [NR*8-1:0] RST = 32'h44332211;

    logic            refClk;
    logic            resetN;
    logic            sel;
    logic            scl;
    logic            hostLow;
    logic            sdaOut;
    logic            sdaOe;
    logic [NR*8-1:0] ctrlRegs;
    wire logic       sdaLine;
    int              miscompares = 0;
    int              testsRun = 0;

    // Pulled-up open-drain wire
    assign sdaLine = !(hostLow || (sdaOe && !sdaOut));

    serial_register_port #(
        .NUM_REGS  (NR),
        .REG_RESET (RST),
        .FILTER_CYC(2)
    ) u_serial_register_port (
        .ref_clk      (refClk),
        .reset_n      (resetN),
        .scl          (scl),
        .sdaIn        (sdaLine),
        .sdaOut       (sdaOut),
        .sdaOe        (sdaOe),
        .addrSelectPin(sel),
        .ctrlRegs     (ctrlRegs)
    );

    host_master u_host_master (
        .clk    (refClk),
        .sdaLine(sdaLine),
        .scl    (scl),
        .hostLow(hostLow)
    );

    initial begin
        refClk = 1'b0;
        forever #2.5 refClk = ~refClk;
    end

    task automatic giveVerdict();
        $display("comparisons %0d, mismatches %0d", testsRun, miscompares);
        if (miscompares == 0 && testsRun > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : giveVerdict

    task automatic check8(input string w, input logic [7:0] e, g);
        testsRun++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", w, e, g);
        end
    endtask : check8

    task automatic checkAck(input string w, input logic e, g);
        testsRun++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %b, seen %b", w, e, g);
        end
    endtask : checkAck

    // Start, address byte with the pin bit, then judge the ack
    task automatic addr(input logic rd, input logic e, input logic gl);
        logic a;
        u_host_master.start();
        u_host_master.sendByte({SLAVE_ADDR_BASE[6:1], sel, rd}, 8, gl, a);
        checkAck("address ack", e, a);
    endtask : addr

    task automatic tx(input logic [7:0] b, input logic e);
        logic a;
        u_host_master.sendByte(b, 8, 1'b0, a);
        checkAck("byte ack", e, a);
    endtask : tx

    task automatic runWrites();
        for (int i = 0; i < NR; i++)
            check8("reset reg", RST[8*i+:8], ctrlRegs[8*i+:8]);
        addr(1'b0, 1'b1, 1'b0);
        tx(8'h01, 1'b1);
        tx(8'hA5, 1'b1);
        u_host_master.stop();
        check8("reg1", 8'hA5, ctrlRegs[15:8]);
        check8("reg0", RST[7:0], ctrlRegs[7:0]);
        addr(1'b0, 1'b1, 1'b0);
        tx(8'h02, 1'b1);
        tx(8'hC3, 1'b1);
        tx(8'h5E, 1'b1);
        tx(8'h77, 1'b0);
        u_host_master.stop();
        check8("reg2", 8'hC3, ctrlRegs[23:16]);
        check8("reg3", 8'h5E, ctrlRegs[31:24]);
        check8("reg0", RST[7:0], ctrlRegs[7:0]);
    endtask : runWrites

    task automatic runRead();
        logic [7:0] got;
        logic [7:0] expd [4] = '{8'hA5, 8'hC3, 8'h5E, 8'h5E};
        addr(1'b0, 1'b1, 1'b0);
        tx(8'h01, 1'b1);
        u_host_master.stop();
        addr(1'b1, 1'b1, 1'b0);
        for (int i = 0; i < 4; i++) begin
            u_host_master.readByte(i < 3, got);
            check8("read byte", expd[i], got);
        end
        u_host_master.stop();
    endtask : runRead

    task automatic runRefuse();
        logic a;
        u_host_master.start();
        u_host_master.sendByte({~SLAVE_ADDR_BASE[6:1], sel, 1'b0}, 8, 1'b0, a);
        checkAck("foreign address ack", 1'b0, a);
        tx(8'h01, 1'b0);
        u_host_master.stop();
        addr(1'b0, 1'b1, 1'b0);
        tx(8'(NR), 1'b0);
        tx(8'h00, 1'b0);
        u_host_master.stop();
        addr(1'b0, 1'b1, 1'b0);
        tx(8'h81, 1'b0);
        tx(8'h00, 1'b0);
        u_host_master.stop();
        check8("reg3", 8'h5E, ctrlRegs[31:24]);
    endtask : runRefuse

    task automatic runAbort();
        logic a;
        addr(1'b0, 1'b1, 1'b0);
        tx(8'h00, 1'b1);
        u_host_master.sendByte(8'hF0, 4, 1'b0, a);
        u_host_master.stop();
        check8("reg0", RST[7:0], ctrlRegs[7:0]);
        u_host_master.start();
        u_host_master.sendByte({SLAVE_ADDR_BASE[6:1], sel, 1'b0}, 4, 1'b0, a);
        addr(1'b0, 1'b1, 1'b0);
        tx(8'h00, 1'b1);
        tx(8'h96, 1'b1);
        u_host_master.stop();
        check8("reg0", 8'h96, ctrlRegs[7:0]);
    endtask : runAbort

    task automatic runFilter();
        @(negedge refClk) sel = 1'b1;
        repeat (10) @(negedge refClk);
        addr(1'b0, 1'b1, 1'b1);
        tx(8'h03, 1'b1);
        tx(8'h3C, 1'b1);
        u_host_master.stop();
        check8("reg3", 8'h3C, ctrlRegs[31:24]);
        @(negedge refClk) sel = 1'b0;
        repeat (10) @(negedge refClk);
        addr(1'b0, 1'b0, 1'b1);
        u_host_master.stop();
    endtask : runFilter

    // Main sequence
    initial begin
        resetN = 1'b1;
        sel = 1'b0;
        #1 resetN = 1'b0;
        repeat (12) @(negedge refClk);
        resetN = 1'b1;
        repeat (3) @(negedge refClk);
        runWrites();
        runRead();
        runRefuse();
        runAbort();
        runFilter();
        giveVerdict();
    end

    // Hang guard
    initial begin
        repeat (100000) @(posedge refClk);
        miscompares++;
        giveVerdict();
    end
endmodule : serial_register_port_bench
